// *** spx_clkdiv.sv ***
// Master SCK rate divider: one-cycle tick every half SCK period.
// Assumes i_half is at least one and stable while i_run is high.
`timescale 1ns/100ps
module spx_clkdiv #(
    parameter int CNT_W = spx_pkg::HALF_W
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_reset,
    // Control
    input  wire logic             i_run,
    input  wire logic [CNT_W-1:0] i_half,
    // Half-period enable
    output logic                  o_tick
);
    if (CNT_W < spx_pkg::HALF_W) begin : g_check
        $error("spx_clkdiv: CNT_W too small for the rate table");
    end

    logic [CNT_W-1:0] count;
    wire              wrap = (count == i_half - CNT_W'(1));

    assign o_tick = i_run & wrap;

    always_ff @(posedge i_clock) begin
        if (i_reset || !i_run || wrap) begin
            count <= '0;
        end else begin
            count <= count + CNT_W'(1);
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    property p_tick_spacing;
        o_tick && (i_half > CNT_W'(1)) && $stable(i_half) |=> !o_tick;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("tick spacing wrong");
endmodule : spx_clkdiv

// *** spx_pkg.sv ***
// Shared constants for the byte-wide serial port: register map, field layout, rates.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package spx_pkg;
    // Register byte addresses
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_STATUS  = 4'h4;
    localparam logic [3:0] ADDR_DATA    = 4'h8;
    localparam logic [3:0] ADDR_PIN_DIR = 4'hc;
    // Control fields
    localparam int CTL_IRQ_EN     = 7;
    localparam int CTL_ENABLE     = 6;
    localparam int CTL_LSB_FIRST  = 5;
    localparam int CTL_MASTER     = 4;
    localparam int CTL_IDLE_LEVEL = 3;
    localparam int CTL_PHASE      = 2;
    localparam int CTL_RATE_HI    = 1;
    localparam int CTL_RATE_LO    = 0;
    // Status fields
    localparam int STS_DONE   = 7;
    localparam int STS_WRITE_COLLISION_FLAG   = 6;
    localparam int STS_DOUBLE = 0;
    // Pin direction fields
    localparam int DIR_MOSI     = 0;
    localparam int DIR_MISO     = 1;
    localparam int DIR_SCK      = 2;
    localparam int DIR_SS       = 3;
    localparam int DIR_SS_LEVEL = 4;
    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] PIN_DIR_RESET = 8'h00;
    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Transfer shape
    localparam logic [4:0] LAST_EDGE = 5'h0f;
    // Half SCK period in system clocks, indexed by {double_rate, rate_select}
    localparam int HALF_W = 7;
    localparam logic [HALF_W-1:0] HALF_PERIOD [0:7] = '{
        7'h02, 7'h08, 7'h20, 7'h40, 7'h01, 7'h04, 7'h10, 7'h20
    };
endpackage : spx_pkg

// *** spx_port.sv ***
// Byte-wide serial port, master or slave, with AXI4-Lite registers.
// Assumes pins are asynchronous; pad logic resolves each pin from its oe_n.
`timescale 1ns/100ps
module spx_port #(
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_reset,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Processor interrupt side
    input  wire logic              i_global_irq_enable,
    input  wire logic              i_irq_vector_ack,
    output logic                   o_transfer_irq,
    // Serial pins
    input  wire logic              i_sck,
    output logic                   o_sck,
    output logic                   o_sck_oe_n,
    input  wire logic              i_mosi,
    output logic                   o_mosi,
    output logic                   o_mosi_oe_n,
    input  wire logic              i_miso,
    output logic                   o_miso,
    output logic                   o_miso_oe_n,
    input  wire logic              i_ss_n,
    output logic                   o_ss_n,
    output logic                   o_ss_oe_n
);
    if (ADDR_W < 4) begin : g_check
        $error("spx_port: ADDR_W must be at least 4");
    end

    // Registers
    logic [7:0]        control;
    logic [7:0]        pin_dir;
    logic              double_rate;
    logic              done_flag;
    logic              write_collision_flag_flag;
    logic              clear_armed;
    logic [7:0]        tx_byte;
    logic [7:0]        rx_byte;
    logic [7:0]        rx_shift;
    logic [4:0]        edge_cnt;
    logic [2:0]        out_idx;
    logic              running;
    logic              sck_out;
    logic              serial_out;
    logic              sck_prev;
    // Bus state
    logic              aw_held;
    logic              w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0]        w_byte;
    logic              w_lane0;

    // Synchronised pins and divider tick
    logic              s_ss_n;
    logic              s_sck;
    logic              s_mosi;
    logic              s_miso;
    logic              tick;

    spx_sync #(
        .WIDTH       (4),
        .RESET_VALUE (4'h8)
    ) u_sync (
        .i_clock (i_clock),
        .i_reset (i_reset),
        .i_async ({i_ss_n, i_sck, i_mosi, i_miso}),
        .o_sync  ({s_ss_n, s_sck, s_mosi, s_miso})
    );

    // Control field decode
    wire enable    = control[spx_pkg::CTL_ENABLE];
    wire master    = control[spx_pkg::CTL_MASTER];
    wire idle_lvl  = control[spx_pkg::CTL_IDLE_LEVEL];
    wire phase     = control[spx_pkg::CTL_PHASE];
    wire lsb_first = control[spx_pkg::CTL_LSB_FIRST];
    wire [2:0] rate_sel = {double_rate, control[spx_pkg::CTL_RATE_HI],
                           control[spx_pkg::CTL_RATE_LO]};

    // Bus decode
    wire aw_fire  = s_axi_awvalid & s_axi_awready;
    wire w_fire   = s_axi_wvalid & s_axi_wready;
    wire ar_fire  = s_axi_arvalid & s_axi_arready;
    wire do_write = aw_held & w_held & ~s_axi_bvalid;
    wire wr_hit_ctl  = (aw_addr == ADDR_W'(spx_pkg::ADDR_CONTROL));
    wire wr_hit_sts  = (aw_addr == ADDR_W'(spx_pkg::ADDR_STATUS));
    wire wr_hit_data = (aw_addr == ADDR_W'(spx_pkg::ADDR_DATA));
    wire wr_hit_dir  = (aw_addr == ADDR_W'(spx_pkg::ADDR_PIN_DIR));
    wire wr_mapped   = wr_hit_ctl | wr_hit_sts | wr_hit_data | wr_hit_dir;
    wire wr_lane     = do_write & w_lane0;
    wire rd_hit_ctl  = (s_axi_araddr == ADDR_W'(spx_pkg::ADDR_CONTROL));
    wire rd_hit_sts  = (s_axi_araddr == ADDR_W'(spx_pkg::ADDR_STATUS));
    wire rd_hit_data = (s_axi_araddr == ADDR_W'(spx_pkg::ADDR_DATA));
    wire rd_hit_dir  = (s_axi_araddr == ADDR_W'(spx_pkg::ADDR_PIN_DIR));
    wire rd_mapped   = rd_hit_ctl | rd_hit_sts | rd_hit_data | rd_hit_dir;
    wire data_write  = wr_lane & wr_hit_data;
    wire data_read   = ar_fire & rd_hit_data;
    wire status_read = ar_fire & rd_hit_sts;
    wire [7:0] status_byte = {done_flag, write_collision_flag_flag, 5'h00, double_rate};
    wire [7:0] rd_byte = rd_hit_ctl  ? control :
                         rd_hit_sts  ? status_byte :
                         rd_hit_data ? rx_byte :
                         rd_hit_dir  ? pin_dir : 8'h00;

    // Role and transfer decode
    wire takeover      = enable & master & ~pin_dir[spx_pkg::DIR_SS] & ~s_ss_n;
    wire slave_active  = enable & ~master & ~s_ss_n;
    wire transfer_busy = running | (edge_cnt != 5'h00);
    wire start         = data_write & enable & master & ~transfer_busy & ~takeover;
    wire slave_abort   = ~master & s_ss_n;
    wire restart       = start | ~enable | takeover | slave_abort;
    wire master_edge   = running & tick;
    wire slave_edge    = slave_active & (s_sck ^ sck_prev);
    wire edge_evt      = (master_edge | slave_edge) & ~restart;
    // Even edge counts are leading edges
    wire sample_evt    = edge_evt & (edge_cnt[0] == phase);
    wire advance       = edge_evt & (edge_cnt[0] != phase) & (edge_cnt != 5'h00);
    wire last_edge     = edge_evt & (edge_cnt == spx_pkg::LAST_EDGE);
    wire data_in       = master ? s_miso : s_mosi;
    wire [2:0] sample_idx   = lsb_first ? edge_cnt[3:1] : ~edge_cnt[3:1];
    wire [2:0] next_out_idx = restart ? 3'h0 : (advance ? out_idx + 3'h1 : out_idx);
    wire [7:0] tx_src       = (data_write & ~transfer_busy) ? w_byte : tx_byte;
    wire [2:0] tx_idx       = lsb_first ? next_out_idx : ~next_out_idx;
    wire       next_serial  = tx_src[tx_idx];

    logic [7:0] next_rx_shift;
    always_comb begin
        next_rx_shift = rx_shift;
        if (sample_evt) begin
            next_rx_shift[sample_idx] = data_in;
        end
    end

    // Flag events; a set wins over a clear
    wire done_set   = last_edge | takeover;
    wire write_collision_flag_set   = data_write & transfer_busy;
    wire clear_pair = clear_armed & (data_write | data_read);

    // Rate applies only to a running master
    spx_clkdiv #(
        .CNT_W (spx_pkg::HALF_W)
    ) u_clkdiv (
        .i_clock (i_clock),
        .i_reset (i_reset),
        .i_run   (running & master),
        .i_half  (spx_pkg::HALF_PERIOD[rate_sel]),
        .o_tick  (tick)
    );

    // Register file
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            control     <= spx_pkg::CONTROL_RESET;
            pin_dir     <= spx_pkg::PIN_DIR_RESET;
            double_rate <= 1'b0;
        end else begin
            if (wr_lane && wr_hit_ctl) begin
                control <= w_byte;
            end else if (takeover) begin
                control[spx_pkg::CTL_MASTER] <= 1'b0;
            end
            if (wr_lane && wr_hit_dir) begin
                pin_dir <= w_byte;
            end
            if (wr_lane && wr_hit_sts) begin
                double_rate <= w_byte[spx_pkg::STS_DOUBLE];
            end
        end
    end

    // Status flags
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            done_flag   <= 1'b0;
            write_collision_flag_flag   <= 1'b0;
            clear_armed <= 1'b0;
        end else begin
            if (done_set) begin
                done_flag <= 1'b1;
            end else if (clear_pair || i_irq_vector_ack) begin
                done_flag <= 1'b0;
            end
            if (write_collision_flag_set) begin
                write_collision_flag_flag <= 1'b1;
            end else if (clear_pair) begin
                write_collision_flag_flag <= 1'b0;
            end
            if (status_read) begin
                clear_armed <= done_flag | write_collision_flag_flag;
            end else if (data_write || data_read) begin
                clear_armed <= 1'b0;
            end
        end
    end

    // Shift engine
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            running    <= 1'b0;
            edge_cnt   <= 5'h00;
            out_idx    <= 3'h0;
            sck_out    <= 1'b0;
            sck_prev   <= 1'b0;
            serial_out <= 1'b0;
            tx_byte    <= 8'h00;
            rx_shift   <= 8'h00;
            rx_byte    <= 8'h00;
        end else begin
            sck_prev   <= s_sck;
            serial_out <= next_serial;
            out_idx    <= next_out_idx;
            rx_shift   <= next_rx_shift;
            if (data_write && !transfer_busy) begin
                tx_byte <= w_byte;
            end
            if (restart || last_edge) begin
                edge_cnt <= 5'h00;
            end else if (edge_evt) begin
                edge_cnt <= edge_cnt + 5'h01;
            end
            running <= start | (running & enable & master & ~takeover & ~last_edge);
            if (!running) begin
                sck_out <= idle_lvl;
            end else if (master_edge) begin
                sck_out <= ~sck_out;
            end
            if (last_edge) begin
                rx_byte <= next_rx_shift;
            end
        end
    end

    // Bus slave
    assign s_axi_awready = ~aw_held;
    assign s_axi_wready  = ~w_held;
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= '0;
            w_byte       <= 8'h00;
            w_lane0      <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= spx_pkg::RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= spx_pkg::RESP_OKAY;
        end else begin
            if (aw_fire) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (w_fire) begin
                w_held  <= 1'b1;
                w_byte  <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end else if (do_write) begin
                w_held <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? spx_pkg::RESP_OKAY : spx_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (ar_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_byte};
                s_axi_rresp  <= rd_mapped ? spx_pkg::RESP_OKAY : spx_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Pins and interrupt
    assign o_sck          = sck_out;
    assign o_sck_oe_n     = ~(enable & master & pin_dir[spx_pkg::DIR_SCK]);
    assign o_mosi         = serial_out;
    assign o_mosi_oe_n    = ~(enable & master & pin_dir[spx_pkg::DIR_MOSI]);
    assign o_miso         = serial_out;
    assign o_miso_oe_n    = ~(slave_active & pin_dir[spx_pkg::DIR_MISO]);
    // Slave select is a plain output when DIR_SS is set, unless the port is an enabled slave
    assign o_ss_n         = pin_dir[spx_pkg::DIR_SS_LEVEL];
    assign o_ss_oe_n      = ~(pin_dir[spx_pkg::DIR_SS] & ~(enable & ~master));
    assign o_transfer_irq = done_flag & control[spx_pkg::CTL_IRQ_EN]
                          & i_global_irq_enable;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    sequence s_takeover;
        takeover && !(wr_lane && wr_hit_ctl);
    endsequence

    property p_irq_gate;
        $rose(done_flag) && control[spx_pkg::CTL_IRQ_EN] && i_global_irq_enable
            |-> o_transfer_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq not raised");

    property p_disabled_idle;
        !enable |=> !running && (edge_cnt == 5'h00);
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) else $error("disabled port moved");

    property p_ss_reset;
        enable && !master && s_ss_n |=> (edge_cnt == 5'h00) && (out_idx == 3'h0);
    endproperty
    a_ss_reset: assert property (p_ss_reset) else $error("slave not reset");

    property p_takeover_role;
        s_takeover |=> !control[spx_pkg::CTL_MASTER] && !running;
    endproperty
    a_takeover_role: assert property (p_takeover_role) else $error("master kept");

    property p_takeover_flag;
        s_takeover |=> done_flag;
    endproperty
    a_takeover_flag: assert property (p_takeover_flag) else $error("flag not set");

    property p_idle_level;
        !running && !$past(running) && $stable(idle_lvl) |-> o_sck == idle_lvl;
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("sck not idle");

    property p_byte_done;
        last_edge |=> done_flag && (rx_byte == $past(next_rx_shift));
    endproperty
    a_byte_done: assert property (p_byte_done) else $error("byte not completed");

    property p_rx_hold;
        !last_edge |=> $stable(rx_byte);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx byte changed");

    property p_write_collision_flag;
        write_collision_flag_set |=> write_collision_flag_flag && $stable(tx_byte);
    endproperty
    a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision missed");

    property p_pair_clear;
        clear_pair && !done_set |=> !done_flag;
    endproperty
    a_pair_clear: assert property (p_pair_clear) else $error("flag not cleared");

    property p_start;
        start |=> running && (tx_byte == $past(w_byte)) && (o_sck == $past(idle_lvl));
    endproperty
    a_start: assert property (p_start) else $error("master did not start");
endmodule : spx_port

// *** spx_port_tb.sv ***
// Self-checking bench: register bus, master transfers, rates, takeover.
// Assumes the remote slave model; pins are resolved here from the enables.
`timescale 1ns/100ps
module spx_port_tb;
    localparam logic [4:0] CTL = {1'b0, spx_pkg::ADDR_CONTROL};
    localparam logic [4:0] STA = {1'b0, spx_pkg::ADDR_STATUS};
    localparam logic [4:0] DAT = {1'b0, spx_pkg::ADDR_DATA};
    localparam logic [4:0] DIR = {1'b0, spx_pkg::ADDR_PIN_DIR};
    logic        i_clock, i_reset, aw_v, w_v, b_r, ar_v, r_r, gie, ack, tb_ss, clock_idle_level, clock_sample_phase, lsb;
    logic        aw_y, w_y, b_v, ar_y, r_v, irq, sck, sck_n, mosi, mosi_n, miso, miso_n;
    logic        ss, ss_n, rmiso;
    logic [4:0]  aw_a, ar_a;
    logic [31:0] w_d, r_d;
    logic [1:0]  b_s, r_s;
    logic [7:0]  rtx, rrx, lf;
    int          num_errors, total_checks, n;
    spx_port #(.ADDR_W(5)) i_dut (.i_clock(i_clock), .i_reset(i_reset),
        .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_y), .s_axi_wdata(w_d),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_y), .s_axi_bresp(b_s),
        .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
        .s_axi_arready(ar_y), .s_axi_rdata(r_d), .s_axi_rresp(r_s), .s_axi_rvalid(r_v),
        .s_axi_rready(r_r), .i_global_irq_enable(gie), .i_irq_vector_ack(ack),
        .o_transfer_irq(irq), .i_sck(sck_n ? 1'b0 : sck), .o_sck(sck), .o_sck_oe_n(sck_n),
        .i_mosi(mosi), .o_mosi(mosi), .o_mosi_oe_n(mosi_n), .i_miso(miso_n ? rmiso : miso),
        .o_miso(miso), .o_miso_oe_n(miso_n), .i_ss_n(ss_n ? tb_ss : ss), .o_ss_n(ss),
        .o_ss_oe_n(ss_n));
    spx_remote i_remote (.i_sck(sck), .i_ss_n(ss_n ? tb_ss : ss), .i_mosi(mosi),
        .o_miso(rmiso), .i_clock_idle_level(clock_idle_level), .i_clock_sample_phase(clock_sample_phase), .i_lsb(lsb), .i_tx(rtx), .o_rx(rrx));
    function automatic logic [7:0] nx(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : nx
    // Half SCK period from the divider table
    function automatic int hp(input logic [2:0] c);
        int d;
        d = (c[1:0] == 2'h3) ? 128 : 4 << (2 * c[1:0]);
        return (d >> c[2]) / 2;
    endfunction : hp
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic ta, tw, tb;
        @(posedge i_clock);
        {aw_a, w_d, aw_v, w_v, b_r} <= {a, 24'h0, d, 3'b111};
        do begin
            @(negedge i_clock);
            {ta, tw, tb} = {aw_v & aw_y, w_v & w_y, b_v};
            @(posedge i_clock);
            if (ta) aw_v <= 1'b0;
            if (tw) w_v <= 1'b0;
        end while (!tb);
        b_r <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [1:0] s = 2'h0);
        logic t;
        @(posedge i_clock);
        {ar_a, ar_v, r_r} <= {a, 2'b11};
        do begin
            @(negedge i_clock);
            t = ar_y;
            @(posedge i_clock);
        end while (!t);
        ar_v <= 1'b0;
        do begin
            @(negedge i_clock);
            t = r_v;
            if (t) chk({r_s, r_d}, {s, 24'h0, e});
            @(posedge i_clock);
        end while (!t);
        r_r <= 1'b0;
    endtask : rd
    task automatic wirq();
        n = 0;
        while (irq !== 1'b1 && n < 5000) begin
            @(negedge i_clock);
            n++;
        end
        chk(n < 5000, 1'b1);
    endtask : wirq
    task automatic print_verdict();
        $display("Checks %0d, errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    // Cut a hang well past the longest expected run
    initial begin
        repeat (60000) @(posedge i_clock);
        num_errors++;
        print_verdict();
    end
    initial begin
        {aw_v, w_v, b_r, ar_v, r_r, ack, aw_a, ar_a, w_d, num_errors, total_checks} = '0;
        {i_reset, gie, tb_ss, lf, rtx, clock_idle_level, clock_sample_phase, lsb} = {3'b111, 8'h23, 11'h0};
        repeat (8) @(posedge i_clock);
        i_reset <= 1'b0;
        rd(CTL, 8'h00);
        rd(STA, 8'h00);
        rd(5'h10, 8'h00, spx_pkg::RESP_SLVERR);
        for (int m = 0; m < 8; m++) begin
            {lsb, clock_sample_phase, clock_idle_level} = 3'(m);
            lf = nx(lf);
            rtx = nx(lf);
            wr(DIR, 8'h1d);
            wr(CTL, {2'b11, lsb, 1'b1, clock_idle_level, clock_sample_phase, 2'b01});
            @(negedge i_clock);
            chk(sck, clock_idle_level);
            wr(DIR, 8'h0d);
            wr(DAT, lf);
            if (m == 0) wr(DAT, 8'h00);
            wirq();
            rd(STA, m == 0 ? 8'hc0 : 8'h80);
            rd(DAT, rtx);
            chk(rrx, lf);
            rd(STA, 8'h00);
        end
        for (int c = 0; c < 8; c++) begin
            wr(STA, {7'h0, c[2]});
            wr(CTL, {6'h35, c[1:0]});
            wr(DAT, 8'ha5);
            @(negedge i_clock);
            while (sck === 1'b0) @(negedge i_clock);
            n = 0;
            while (sck === 1'b1 && n < 300) begin
                @(negedge i_clock);
                n++;
            end
            chk(n, hp(3'(c)));
            wirq();
            ack <= 1'b1;
            @(posedge i_clock);
            ack <= 1'b0;
            rd(STA, {7'h0, c[2]});
        end
        wr(DIR, 8'h05);
        wr(CTL, 8'hd0);
        tb_ss <= 1'b0;
        repeat (6) @(posedge i_clock);
        rd(CTL, 8'hc0);
        rd(STA, 8'h81);
        chk({sck_n, irq}, 2'b11);
        gie <= 1'b0;
        @(negedge i_clock);
        chk(irq, 1'b0);
        print_verdict();
    end
endmodule : spx_port_tb

// *** spx_remote.sv ***
// Behavioural remote slave on the far side of the serial pins.
// Assumes SCK moves only while selected; mode inputs are set per byte.
`timescale 1ns/100ps
module spx_remote (
    // Pins
    input  wire logic       i_sck,
    input  wire logic       i_ss_n,
    input  wire logic       i_mosi,
    output logic            o_miso,
    // Mode and data
    input  wire logic       i_clock_idle_level,
    input  wire logic       i_clock_sample_phase,
    input  wire logic       i_lsb,
    input  wire logic [7:0] i_tx,
    output logic      [7:0] o_rx
);
    logic [7:0] sh;
    initial o_miso = 1'b0;
    always @(negedge i_ss_n) begin
        sh = i_tx;
        o_miso = i_lsb ? i_tx[0] : i_tx[7];
    end
    // Released line must not hold its last bit
    always @(posedge i_ss_n) o_miso = ~o_miso;
    always @(i_sck) begin
        if (!i_ss_n && ((i_sck != i_clock_idle_level) ^ i_clock_sample_phase)) begin
            o_rx = i_lsb ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
            sh = i_lsb ? sh >> 1 : sh << 1;
        end else if (!i_ss_n) begin
            o_miso = i_lsb ? sh[0] : sh[7];
        end
    end
endmodule : spx_remote

// *** spx_sync.sv ***
// Two-flop synchronisers for the serial port pins.
// Assumes the inputs are asynchronous to i_clock.
`timescale 1ns/100ps
module spx_sync #(
    parameter int               WIDTH       = 4,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_reset,
    // Pins in, synchronised out
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
        always_ff @(posedge i_clock) begin
            if (i_reset) begin
                stage1[b] <= RESET_VALUE[b];
                o_sync[b] <= RESET_VALUE[b];
            end else begin
                stage1[b] <= i_async[b];
                o_sync[b] <= stage1[b];
            end
        end
    end
endmodule : spx_sync
